// file: verilog/multiphase_pulse_engine_compensator.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
// What this block does
// R1 - Gain stage, biquad, then first-order filter.
// R2 - Three banks: ramp, regulation, light load.
// R3 - Four signed limits pick gain region.
// R4 - All-positive limits: gain zero governs negatives.
// R5 - First-order section adds third zero, pole.
// R6 - Duty times period gives compare threshold.
// R7 - Period counter compare sets pulse width.
// R8 - Engines follow sync in; sync out driven.
// R9 - Host configures sync by vendor command.
// R10 - One or two rails, four stages max.
// R11 - Fixed stage-to-rail mapping per split.
// R12 - Host never requests zero-stage rail one.
// R13 - Host picks stages in listed order.
// R14 - Rail two delayed 3/13 fastest period.
// R15 - Stage edges spaced period over count.
// R16 - Counter restarts; pulse from offset to threshold.
// R17 - Bank switches only at period boundary.
// R18 - Error saturates; reference slews while saturated.
// R19 - Sync rising edge resets following counters.
module multiphase_pulse_engine_compensator (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  err_rail1,
  input  wire logic [5:0]  err_rail2,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic [3:0]       gate_drive,
  output logic [1:0]       ref_up,
  output logic [1:0]       ref_down
);
  localparam int PW = pulse_engine_pkg::PER_W;
  localparam int CB = pulse_engine_pkg::NCOEF * pulse_engine_pkg::COEF_W;

  // Registers.
  logic [3:0]  ctrl;        // [1:0] rail1 mode, [3:2] rail2 mode
  logic [3:0]  split;       // stage_assignment_command: [1:0] rail2 cnt, [3:2]... see decode
  logic [31:0] period;      // [15:0] rail1, [31:16] rail2
  logic [15:0] sync_cfg;    // vendor_command word: [15:8] out select, [1:0] follow
  logic [31:0] limits;
  logic [15:0] coef_mem [0:2*3*pulse_engine_pkg::NCOEF-1];

  // APB decode; every access completes with no wait state.
  wire logic       acc     = psel & penable;
  wire logic       wr      = acc & pwrite;
  wire logic [11:0] coff   = paddr - pulse_engine_pkg::OFS_COEF;
  wire logic       is_coef = (paddr >= pulse_engine_pkg::OFS_COEF) & (coff[11:9] == 3'h0) &
                             (paddr[1:0] == 2'b00);
  wire logic [6:0] cidx    = coff[8:2];
  wire logic       coef_ok = is_coef & (cidx < 7'(2*3*pulse_engine_pkg::NCOEF));
  wire logic       known   = coef_ok | (paddr == pulse_engine_pkg::OFS_CTRL) |
                             (paddr == pulse_engine_pkg::OFS_SPLIT) | (paddr == pulse_engine_pkg::OFS_PERIOD) |
                             (paddr == pulse_engine_pkg::OFS_SYNC) | (paddr == pulse_engine_pkg::OFS_LIMITS) |
                             (paddr == pulse_engine_pkg::OFS_STATUS) | (paddr == pulse_engine_pkg::OFS_ERR);

  // Rail stage counts: split[3:2]+1 on rail 1 (1..4), split[1:0] on rail 2.
  wire logic [2:0] n1 = {1'b0, split[3:2]} + 3'd1; // [R10]
  wire logic [1:0] n2 = split[1:0];
  wire logic       two = (n2 != 2'd0);

  // Stage ownership per split: the stage_third slot goes to rail 2 when it exists. [R11]
  // Rail-1 phase slot order is first, second, fourth-or-third.
  wire logic [3:0] en;
  wire logic [3:0] on_r2;
  wire logic [1:0] slot [0:3];
  assign en[0]    = 1'b1;
  assign en[1]    = n1 >= 3'd2;
  assign en[2]    = two ? 1'b1 : (n1 >= 3'd3);
  assign en[3]    = two ? ((n1 >= 3'd3) | (n2 >= 2'd2)) : (n1 == 3'd4);
  assign on_r2[0] = 1'b0;
  assign on_r2[1] = 1'b0;
  assign on_r2[2] = two;
  assign on_r2[3] = two & (n2 >= 2'd2);
  assign slot[0]  = 2'd0;
  assign slot[1]  = 2'd1;
  assign slot[2]  = two ? 2'd0 : 2'd2;
  assign slot[3]  = two ? ((n2 >= 2'd2) ? 2'd1 : 2'd2) : 2'd3;

  // Sync input passes two flops before any edge detect.
  logic [1:0] sync_sr;
  logic       sync_d;
  wire logic  sync_rise = sync_sr[1] & ~sync_d;

  // Per-rail period counters and boundaries.
  logic [PW-1:0] cnt [0:1];
  wire logic [PW-1:0] per [0:1];
  assign per[0] = period[15:0];
  assign per[1] = period[31:16];
  wire logic [1:0] bnd;
  logic [1:0] bank_mode [0:1];
  logic [1:0] sat_lo, sat_hi;
  wire logic [15:0] duty [0:1];
  wire logic [5:0] err [0:1];
  assign err[0] = err_rail1;
  assign err[1] = err_rail2;

  // Fastest period sets rail-to-rail spread. [R14]
  wire logic [PW-1:0] tfast  = (two && per[1] < per[0]) ? per[1] : per[0];
  wire logic [PW+3:0] spr_p  = (PW+4)'(tfast) * 4'(pulse_engine_pkg::SPREAD_NUM);
  wire logic [PW-1:0] spread = PW'(spr_p / (PW+4)'(pulse_engine_pkg::SPREAD_DEN));

  genvar r;
  generate
    for (r = 0; r < pulse_engine_pkg::NRAIL; r++) begin : g_rail
      wire logic fol = sync_cfg[r];
      wire logic [CB-1:0] cvec;
      wire logic [5:0] esat;
      for (genvar k = 0; k < pulse_engine_pkg::NCOEF; k++) begin : g_c
        assign cvec[k*16 +: 16] = coef_mem[(r*3 + int'(bank_mode[r]))*pulse_engine_pkg::NCOEF + k];
      end
      // Converter output clamped to its saturation range. [R18]
      assign esat = ($signed(err[r]) <= pulse_engine_pkg::ERR_MIN) ? pulse_engine_pkg::ERR_MIN :
                    ($signed(err[r]) >= pulse_engine_pkg::ERR_MAX) ? pulse_engine_pkg::ERR_MAX : err[r];
      assign bnd[r] = (cnt[r] >= per[r] - PW'(1)) | (fol & sync_rise);
      // Filter advances once per period; limits apply per R3 and R4. [R1] [R3] [R4] [R5]
      rail_compensator u_comp (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (bnd[r]),
        .err_in  (esat),
        .limits  (limits),
        .coef    (cvec),
        .duty    (duty[r])
      );
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt[r]       <= '0;
          bank_mode[r] <= 2'(pulse_engine_pkg::MODE_RAMP);
          sat_lo[r]    <= 1'b0;
          sat_hi[r]    <= 1'b0;
        end else begin
          cnt[r] <= bnd[r] ? '0 : cnt[r] + PW'(1); // [R16] [R19]
          if (bnd[r]) begin
            bank_mode[r] <= ctrl[2*r +: 2]; // [R2] [R17]
          end
          sat_lo[r] <= $signed(err[r]) <= pulse_engine_pkg::ERR_MIN; // [R18]
          sat_hi[r] <= $signed(err[r]) >= pulse_engine_pkg::ERR_MAX;
        end
      end
    end
  endgenerate

  // Thresholds: duty scaled by period. [R6]
  wire logic [31:0] th_p [0:1];
  assign th_p[0] = duty[0] * per[0];
  assign th_p[1] = duty[1] * per[1];

  genvar s;
  generate
    for (s = 0; s < pulse_engine_pkg::NSTAGE; s++) begin : g_stage
      wire logic       rr   = on_r2[s];
      wire logic [2:0] nph  = rr ? {1'b0, n2} : n1;
      wire logic [PW-1:0] p = rr ? per[1] : per[0];
      wire logic [PW-1:0] c = rr ? cnt[1] : cnt[0];
      // Phase offset: slot share of period plus rail spread. [R15] [R14]
      wire logic [PW+1:0] sh = (PW+2)'(p) * (PW+2)'(slot[s]);
      wire logic [PW-1:0] off0 = PW'(sh / (PW+2)'(nph));
      wire logic [PW:0]   offs = (PW+1)'(off0) + (rr ? (PW+1)'(spread) : '0);
      wire logic [PW-1:0] off  = (offs >= (PW+1)'(p)) ? PW'(offs - (PW+1)'(p)) : PW'(offs);
      wire logic [PW-1:0] th   = rr ? th_p[1][31:16] : th_p[0][31:16];
      // Time since this stage's start point, wrapped in the period.
      wire logic [PW-1:0] rel  = (c >= off) ? c - off : PW'((PW+1)'(c) + (PW+1)'(p) - (PW+1)'(off));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gate_drive[s] <= 1'b0;
        end else begin
          gate_drive[s] <= en[s] & (rel < th); // [R7] [R16]
        end
      end
    end
  endgenerate

  // Sync out: selected stage's gate pulse, registered one cycle later. [R8]
  wire logic [7:0] so_sel = sync_cfg[15:8];
  wire logic       so_ok  = so_sel < 8'd4;
  wire logic       so_val = so_ok & gate_drive[so_sel[1:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sr  <= 2'b00;
      sync_d   <= 1'b0;
      sync_out <= 1'b0;
      ref_up   <= 2'b00;
      ref_down <= 2'b00;
    end else begin
      sync_sr  <= {sync_sr[0], sync_in};
      sync_d   <= sync_sr[1];
      sync_out <= so_val;
      // Reference slews up on positive-rail saturation, down on negative. [R18]
      ref_up   <= sat_hi;
      ref_down <= sat_lo;
    end
  end

  // Register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= '0;
      split    <= pulse_engine_pkg::RST_SPLIT[3:0];
      period   <= pulse_engine_pkg::RST_PERIOD | (pulse_engine_pkg::RST_PERIOD << 16);
      sync_cfg <= pulse_engine_pkg::RST_SYNC[15:0];
      limits   <= pulse_engine_pkg::RST_LIMITS;
    end else if (wr) begin
      if (paddr == pulse_engine_pkg::OFS_CTRL)   ctrl     <= pwdata[3:0];
      if (paddr == pulse_engine_pkg::OFS_SPLIT)  split    <= pwdata[3:0];
      if (paddr == pulse_engine_pkg::OFS_PERIOD) period   <= pwdata;
      if (paddr == pulse_engine_pkg::OFS_SYNC)   sync_cfg <= pwdata[15:0];
      if (paddr == pulse_engine_pkg::OFS_LIMITS) limits   <= pwdata;
    end
  end

  // Coefficients clear on reset, so an unwritten bank holds the filter at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2*3*pulse_engine_pkg::NCOEF; i++) coef_mem[i] <= '0;
    end else if (wr && coef_ok) begin
      coef_mem[cidx] <= pwdata[15:0];
    end
  end

  // Read mux.
  wire logic [31:0] rd =
    (paddr == pulse_engine_pkg::OFS_CTRL)   ? {28'h0, ctrl} :
    (paddr == pulse_engine_pkg::OFS_SPLIT)  ? {28'h0, split} :
    (paddr == pulse_engine_pkg::OFS_PERIOD) ? period :
    (paddr == pulse_engine_pkg::OFS_SYNC)   ? {16'h0, sync_cfg} :
    (paddr == pulse_engine_pkg::OFS_LIMITS) ? limits :
    (paddr == pulse_engine_pkg::OFS_STATUS) ? {20'h0, bank_mode[1], bank_mode[0], sat_hi, sat_lo,
                                       gate_drive} :
    (paddr == pulse_engine_pkg::OFS_ERR)    ? {duty[1], duty[0]} :
    coef_ok ? {16'h0, coef_mem[cidx]} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h0;
    end
  end
endmodule

// file: verilog/pulse_engine_pkg.sv
package pulse_engine_pkg;

  // Word widths, stage count and rail count of the control path.
  localparam int ERR_W   = 6;
  localparam int COEF_W  = 16;
  localparam int ACC_W   = 32;
  localparam int DUTY_W  = 16;
  localparam int PER_W   = 16;
  localparam int NSTAGE  = 4;
  localparam int NRAIL   = 2;

  // Error converter saturation limits.
  localparam logic signed [ERR_W-1:0] ERR_MIN = -6'sd32;
  localparam logic signed [ERR_W-1:0] ERR_MAX = 6'sd31;

  // Rail-to-rail spread ratio, numerator over denominator.
  localparam int SPREAD_NUM = 3;
  localparam int SPREAD_DEN = 13;

  // Full-scale duty value stands for 100 percent.
  localparam logic [DUTY_W-1:0] DUTY_FULL = 16'hffff;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_SPLIT   = 12'h004;
  localparam logic [11:0] OFS_PERIOD  = 12'h008;
  localparam logic [11:0] OFS_SYNC    = 12'h00c;
  localparam logic [11:0] OFS_LIMITS  = 12'h010;
  localparam logic [11:0] OFS_STATUS  = 12'h014;
  localparam logic [11:0] OFS_ERR     = 12'h018;
  localparam logic [11:0] OFS_COEF    = 12'h100;

  // Reset values.
  localparam logic [31:0] RST_PERIOD  = 32'h0000_00c8;
  // Split resets to four stages on rail 1 and none on rail 2.
  localparam logic [31:0] RST_SPLIT   = 32'h0000_000c;
  localparam logic [31:0] RST_SYNC    = 32'h0000_ff00;
  localparam logic [31:0] RST_LIMITS  = 32'h1f01_fee0;

  // Compensator operating modes selecting coefficient bank.
  typedef enum logic [1:0] {
    MODE_RAMP  = 2'b00,
    MODE_REG   = 2'b01,
    MODE_LIGHT = 2'b10
  } bank_t;

  // Coefficient slots per bank: 5 gains, b0 b1 b2 a1 a2, c0 c1 d1.
  localparam int NCOEF = 13;

endpackage

// file: verilog/rail_compensator.sv
`timescale 1ns/10ps
module rail_compensator (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             step,
  input  wire logic signed [pulse_engine_pkg::ERR_W-1:0] err_in,
  input  wire logic [31:0]                      limits,
  input  wire logic [pulse_engine_pkg::NCOEF*pulse_engine_pkg::COEF_W-1:0] coef,
  output logic [pulse_engine_pkg::DUTY_W-1:0]           duty
);
  localparam int CW = pulse_engine_pkg::COEF_W;
  localparam int AW = pulse_engine_pkg::ACC_W;

  function automatic logic signed [CW-1:0] cf(input int i);
    cf = $signed(coef[i*CW +: CW]);
  endfunction

  // Nonlinear gain region select from four signed limits.
  wire logic signed [7:0] l0 = $signed(limits[7:0]);
  wire logic signed [7:0] l1 = $signed(limits[15:8]);
  wire logic signed [7:0] l2 = $signed(limits[23:16]);
  wire logic signed [7:0] l3 = $signed(limits[31:24]);
  wire logic signed [7:0] e8 = 8'(err_in);
  wire logic [2:0] region = (e8 < l0) ? 3'h0 : (e8 < l1) ? 3'h1 : (e8 <= l2) ? 3'h2 :
                            (e8 <= l3) ? 3'h3 : 3'h4;
  wire logic signed [CW-1:0] gain = cf(int'(region));
  wire logic signed [AW-1:0] x = AW'(e8 * gain);

  logic signed [AW-1:0] x1, x2, y1, y2, z1, w1;
  // Second-order section, coefficients in Q8.
  wire logic signed [AW+15:0] acc2 = (AW+16)'(x * cf(5)) + (AW+16)'(x1 * cf(6)) +
                                     (AW+16)'(x2 * cf(7)) + (AW+16)'(y1 * cf(8)) +
                                     (AW+16)'(y2 * cf(9));
  wire logic signed [AW-1:0] y = AW'(acc2 >>> 8);
  // First-order section supplies the third zero and pole.
  wire logic signed [AW+15:0] acc1 = (AW+16)'(y * cf(10)) + (AW+16)'(z1 * cf(11)) +
                                     (AW+16)'(w1 * cf(12));
  wire logic signed [AW-1:0] w = AW'(acc1 >>> 8);
  wire logic [pulse_engine_pkg::DUTY_W-1:0] next_duty =
    (w < 0) ? '0 : (w > AW'(pulse_engine_pkg::DUTY_FULL)) ? pulse_engine_pkg::DUTY_FULL : w[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1 <= '0; x2 <= '0; y1 <= '0; y2 <= '0; z1 <= '0; w1 <= '0; duty <= '0;
    end else if (step) begin
      x1 <= x; x2 <= x1; y1 <= y; y2 <= y1; z1 <= y; w1 <= w;
      duty <= next_duty;
    end
  end
endmodule

// file: verification/pulse_engine_properties.sv
`timescale 1ns/10ps
module pulse_engine_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [5:0] err_rail1,
  input wire logic       sync_out,
  input wire logic [3:0] gate_drive,
  input wire logic [1:0] ref_up,
  input wire logic [1:0] ref_down
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  AST_READY_SINGLE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_SLVERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> gate_drive == 4'h0 && !sync_out)
    else $error("outputs active after reset");
  AST_SYNC_FROM_STAGE: assert property (sync_out |-> (|gate_drive) || (|$past(gate_drive)))
    else $error("sync out without stage pulse");
  AST_REF_UP_CAUSE: assert property ($rose(ref_up[0]) |-> err_rail1 == 6'h1f)
    else $error("ref up without positive saturation");
  AST_REF_DOWN_CAUSE: assert property ($rose(ref_down[0]) |-> err_rail1 == 6'h20)
    else $error("ref down without negative saturation");
  AST_REF_EXCLUSIVE: assert property (!(ref_up[0] && ref_down[0]))
    else $error("reference slewed both ways");
endmodule

// file: verification/sync_peer.sv
`timescale 1ns/10ps
module sync_peer (
  input  wire logic        pclk,
  input  wire logic        enable,
  input  wire logic [15:0] interval,
  output logic             sync_in = 1'b0
);
  int cnt = 0;
  // A peer controller leading the period; when idle it drives its line low.
  always @(posedge pclk) begin
    cnt <= (!enable || cnt >= int'(interval) - 1) ? 0 : cnt + 1;
    sync_in <= enable && cnt < 4;
  end
endmodule

// file: verification/tb_multiphase_pulse_engine_compensator.sv
`timescale 1ns/10ps
module tb_multiphase_pulse_engine_compensator;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v;
  logic [5:0]  err_rail1 = '0, err_rail2 = '0;
  logic        pready, pslverr, sync_out, sync_in, re, peer_en = 1'b0, so_seen = 1'b0;
  logic [3:0]  gate_drive, prev_g = '0;
  logic [1:0]  ref_up, ref_down;
  int          n_errors = 0, num_checks = 0, cyc = 0, d1;
  int          rise_t[4], per_t[4], wid[4], hi[4];
  always #2.5 pclk = ~pclk;
  multiphase_pulse_engine_compensator i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_rail1(err_rail1), .err_rail2(err_rail2),
    .sync_in(sync_in), .sync_out(sync_out), .gate_drive(gate_drive), .ref_up(ref_up),
    .ref_down(ref_down));
  sync_peer i_peer (.pclk(pclk), .enable(peer_en), .interval(16'd80), .sync_in(sync_in));
  // Edge times, rise-to-rise spacing and high widths of every stage, in clock cycles.
  always @(posedge pclk) begin
    cyc++;
    if (sync_out === 1'b1) so_seen = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (gate_drive[i] === 1'b1 && !prev_g[i]) begin
        per_t[i] = cyc - rise_t[i];
        rise_t[i] = cyc;
      end
      if (gate_drive[i] === 1'b1) hi[i]++;
      else if (prev_g[i]) begin
        wid[i] = hi[i];
        hi[i] = 0;
      end
    end
    prev_g = gate_drive;
  end
  function automatic int md(input int x);
    return ((x % 104) + 104) % 104;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // The request is held until pready is seen; the next call or wait_cyc releases it.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    re = pslverr;
    if (n >= 16) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wait_cyc(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(32'h759c));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, pulse_engine_pkg::OFS_PERIOD, 0);
    chk("period", {pulse_engine_pkg::RST_PERIOD[15:0], pulse_engine_pkg::RST_PERIOD[15:0]}, rd);
    apb(0, pulse_engine_pkg::OFS_SPLIT, 0); chk("split", pulse_engine_pkg::RST_SPLIT, rd);
    apb(0, pulse_engine_pkg::OFS_SYNC, 0); chk("sync", pulse_engine_pkg::RST_SYNC, rd);
    apb(0, pulse_engine_pkg::OFS_LIMITS, 0); chk("limits", pulse_engine_pkg::RST_LIMITS, rd);
    apb(0, 12'h01c, 0); chk("unmapped", 32'h1, {rd[30:0] | rd[31], re});
    v = $urandom;
    apb(1, pulse_engine_pkg::OFS_LIMITS, v); apb(0, pulse_engine_pkg::OFS_LIMITS, 0); chk("limits_rw", v, rd);
    apb(1, pulse_engine_pkg::OFS_LIMITS, pulse_engine_pkg::RST_LIMITS);
    $display("test registers done");
    for (int r = 0; r < 2; r++)
      for (int k = 0; k < 13; k++)
        apb(1, pulse_engine_pkg::OFS_COEF + 12'(4 * ((r * 3 + 1) * 13 + k)),
            (k <= 5 || k == 10) ? 32'h100 : 32'h0);
    apb(1, pulse_engine_pkg::OFS_CTRL, 32'h5);
    apb(1, pulse_engine_pkg::OFS_PERIOD, {16'd104, 16'd104});
    err_rail1 <= 6'd8;
    err_rail2 <= 6'($urandom_range(1, 30));
    wait_cyc(104 * 10);
    apb(0, pulse_engine_pkg::OFS_ERR, 0);
    d1 = int'(rd[15:0]);
    chk("duty", 8 * 256, d1);
    chk("width", (d1 * 104) >> 16, wid[0]);
    chk("period_rise", 104, per_t[0]);
    for (int k = 1; k < 4; k++) chk("phase_4_0", 26 * k, md(rise_t[k] - rise_t[0]));
    $display("test single rail done");
    apb(1, pulse_engine_pkg::OFS_SPLIT, 32'h6);
    wait_cyc(104 * 6);
    chk("phase_rail1", 52, md(rise_t[1] - rise_t[0]));
    chk("rail_spread", 24, md(rise_t[2] - rise_t[0]));
    chk("phase_rail2", 52, md(rise_t[3] - rise_t[2]));
    apb(1, pulse_engine_pkg::OFS_CTRL, 32'ha);
    wait_cyc(104 * 3);
    chk("bank_switch", 104, per_t[0]);
    apb(0, pulse_engine_pkg::OFS_STATUS, 0);
    chk("bank_mode", 4'ha, rd[11:8]);
    apb(1, pulse_engine_pkg::OFS_CTRL, 32'h5);
    $display("test two rails done");
    apb(1, pulse_engine_pkg::OFS_SYNC, 32'h0);
    wait_cyc(104 * 3);
    chk("sync_out", 1, so_seen);
    apb(1, pulse_engine_pkg::OFS_SYNC, 32'hff01);
    peer_en <= 1'b1;
    wait_cyc(80 * 6);
    chk("follow", 80, per_t[0]);
    peer_en <= 1'b0;
    $display("test sync done");
    err_rail1 <= 6'h1f;
    wait_cyc(104 * 3);
    chk("ref_up", 1, ref_up[0]);
    err_rail1 <= 6'h20;
    wait_cyc(104 * 3);
    chk("ref_down", 1, ref_down[0]);
    err_rail1 <= 6'd3;
    wait_cyc(104 * 3);
    chk("ref_idle", 0, {ref_up[0], ref_down[0]});
    $display("test saturation done");
    presetn <= 1'b0;
    wait_cyc(2);
    chk("reset_gate", 0, gate_drive);
    presetn <= 1'b1;
    wait_cyc(4);
    $display("test reset done");
    complete_run();
  end
endmodule
bind multiphase_pulse_engine_compensator pulse_engine_properties i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .err_rail1(err_rail1),
  .sync_out(sync_out), .gate_drive(gate_drive), .ref_up(ref_up), .ref_down(ref_down));
